// File: verilog/mia_core.v
`timescale 1ns/1ns
`include "mia_consts.vh"
////////////////////////////////////////////////////////////////////////////
module mia_core (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [`MIA_NSRC-1:0] src_req_i,
   input wire [`MIA_NSRC-1:0] pend_clr_i,
   input wire [`MIA_NSRC*3-1:0] lvl_wdata_i,
   input wire [`MIA_NSRC-1:0] lvl_we_i,
   input wire [2:0] special_i,
   input wire [5:0] special_vec_i,
   input wire trap_i,
   input wire [5:0] trap_num_i,
   input wire instr_done_i,
   input wire suspendable_i,
   input wire return_from_exception_instr_i,
   input wire [7:0] flg_i,
   input wire [2:0] ipl_i,
   input wire [19:0] pc_i,
   input wire [19:0] vector_table_base_i,
   input wire [19:0] vec_rdata_i,
   input wire [15:0] stack_rdata_i,
   output reg [`MIA_NSRC-1:0] pend_o,
   output reg [`MIA_NSRC*3-1:0] lvl_o,
   output reg busy_o,
   output reg info_rd_o,
   output reg [19:0] info_addr_o,
   output reg [5:0] int_num_o,
   output reg [2:0] int_lvl_o,
   output reg stack_we_o,
   output reg stack_re_o,
   output reg [7:0] stack_wdata_o,
   output reg [1:0] stack_idx_o,
   output reg vec_rd_o,
   output reg [19:0] vec_addr_o,
   output reg flg_we_o,
   output reg [7:0] flg_o,
   output reg ipl_we_o,
   output reg [2:0] ipl_o,
   output reg pc_we_o,
   output reg [19:0] pc_o,
   output reg suspend_o,
   output reg done_o
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_ENTRY = 4'h2;
   localparam [3:0] ST_RET = 4'h4;
   localparam [3:0] ST_END = 4'h8;

   reg [3:0] state_reg;
   reg [4:0] cyc_reg;
   reg [7:0] tmp_flg_reg;
   reg [19:0] tmp_pc_reg;
   reg [2:0] tmp_ipl_reg;
   reg [2:0] new_ipl_reg;
   reg ipl_load_reg;
   reg keep_u_reg;
   reg mask_src_reg;
   reg [4:0] src_reg;
   reg [15:0] pop_hi_reg;
   wire hit;
   wire [4:0] hit_num;
   wire [2:0] hit_lvl;
   wire boundary = instr_done_i | suspendable_i;
   wire [15:0] save_hi = {tmp_pc_reg[19:16], 1'b0, tmp_ipl_reg, tmp_flg_reg};
   wire [15:0] save_lo = tmp_pc_reg[15:0];
   genvar g;

   mia_arbiter u_arb (
      .pend_i(pend_o),
      .lvl_i(lvl_o),
      .ipl_i(ipl_i),
      .i_flag_i(flg_i[`MIA_FLG_I]),
      .hit_o(hit),
      .num_o(hit_num),
      .lvl_o(hit_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per-source control: own level and own pending bit.
   generate
      for (g = 0; g < `MIA_NSRC; g = g + 1) begin : g_src
         wire accept_me = (state_reg == ST_ENTRY) && (cyc_reg == 5'd0) && mask_src_reg &&
                          (src_reg == g);
         always @(posedge core_clk_i) begin
            if (!rst_n_i) begin
               pend_o[g] <= 1'b0;
               lvl_o[g*3 +: 3] <= 3'h0;
            end else begin
               if (lvl_we_i[g]) begin
                  lvl_o[g*3 +: 3] <= lvl_wdata_i[g*3 +: 3];
               end
               // A new request wins over a clear in the same cycle, so no event is lost.
               if (src_req_i[g]) begin
                  pend_o[g] <= 1'b1;
               end else if (pend_clr_i[g] || accept_me) begin
                  pend_o[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Entry and return sequencer.
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         cyc_reg <= 5'd0;
         tmp_flg_reg <= 8'h00;
         tmp_pc_reg <= 20'h00000;
         tmp_ipl_reg <= 3'h0;
         new_ipl_reg <= 3'h0;
         ipl_load_reg <= 1'b0;
         keep_u_reg <= 1'b0;
         mask_src_reg <= 1'b0;
         src_reg <= 5'd0;
         pop_hi_reg <= 16'h0000;
         busy_o <= 1'b0;
         info_rd_o <= 1'b0;
         info_addr_o <= 20'h00000;
         int_num_o <= 6'h00;
         int_lvl_o <= 3'h0;
         stack_we_o <= 1'b0;
         stack_re_o <= 1'b0;
         stack_wdata_o <= 8'h00;
         stack_idx_o <= 2'd0;
         vec_rd_o <= 1'b0;
         vec_addr_o <= 20'h00000;
         flg_we_o <= 1'b0;
         flg_o <= 8'h00;
         ipl_we_o <= 1'b0;
         ipl_o <= 3'h0;
         pc_we_o <= 1'b0;
         pc_o <= 20'h00000;
         suspend_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         info_rd_o <= 1'b0;
         stack_we_o <= 1'b0;
         stack_re_o <= 1'b0;
         vec_rd_o <= 1'b0;
         flg_we_o <= 1'b0;
         ipl_we_o <= 1'b0;
         pc_we_o <= 1'b0;
         suspend_o <= 1'b0;
         done_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // The decision is latched here once, so a clear in the same cycle
               // as the boundary cannot start a sequence later on stale state.
               if (return_from_exception_instr_i) begin
                  state_reg <= ST_RET;
                  cyc_reg <= 5'd0;
                  busy_o <= 1'b1;
               end else if (trap_i || (boundary &&
                            ((special_i != `MIA_SP_NONE) || hit))) begin
                  state_reg <= ST_ENTRY;
                  cyc_reg <= 5'd0;
                  busy_o <= 1'b1;
                  suspend_o <= suspendable_i && !instr_done_i;
                  tmp_flg_reg <= flg_i;
                  tmp_pc_reg <= pc_i;
                  tmp_ipl_reg <= ipl_i;
                  keep_u_reg <= 1'b0;
                  mask_src_reg <= 1'b0;
                  ipl_load_reg <= 1'b0;
                  if (trap_i) begin
                     int_num_o <= trap_num_i;
                     int_lvl_o <= ipl_i;
                     keep_u_reg <= (trap_num_i >= `MIA_SW_U_LO);
                  end else if (special_i != `MIA_SP_NONE) begin
                     int_num_o <= special_vec_i;
                     int_lvl_o <= `MIA_IPL_SPECIAL;
                     ipl_load_reg <= (special_i == `MIA_SP_WDT) || (special_i == `MIA_SP_VMON) ||
                                     (special_i == `MIA_SP_CMP) ||
                                     (special_i == `MIA_SP_ABRK);
                     new_ipl_reg <= `MIA_IPL_SPECIAL;
                  end else begin
                     int_num_o <= {1'b0, hit_num};
                     int_lvl_o <= hit_lvl;
                     src_reg <= hit_num;
                     mask_src_reg <= 1'b1;
                     ipl_load_reg <= 1'b1;
                     new_ipl_reg <= hit_lvl;
                  end
               end
            end
            ST_ENTRY: begin
               cyc_reg <= cyc_reg + 5'd1;
               case (cyc_reg)
                  5'd0: begin
                     info_rd_o <= 1'b1;
                     info_addr_o <= `MIA_INFO_ADDR;
                  end
                  5'd2: begin
                     flg_we_o <= 1'b1;
                     flg_o <= tmp_flg_reg & ~((8'h01 << `MIA_FLG_I) | (8'h01 << `MIA_FLG_D) |
                              (keep_u_reg ? 8'h00 : (8'h01 << `MIA_FLG_U)));
                  end
                  5'd4, 5'd6, 5'd8, 5'd10: begin
                     stack_we_o <= 1'b1;
                     stack_idx_o <= cyc_reg[2:1] - 2'd2;
                     case (cyc_reg)
                        5'd4: stack_wdata_o <= save_hi[15:8];
                        5'd6: stack_wdata_o <= save_hi[7:0];
                        5'd8: stack_wdata_o <= save_lo[15:8];
                        default: stack_wdata_o <= save_lo[7:0];
                     endcase
                  end
                  5'd12: begin
                     if (ipl_load_reg) begin
                        ipl_we_o <= 1'b1;
                        ipl_o <= new_ipl_reg;
                     end
                  end
                  5'd14: begin
                     vec_rd_o <= 1'b1;
                     vec_addr_o <= vector_table_base_i + {12'h000, int_num_o, 2'b00};
                  end
                  5'd18: begin
                     pc_we_o <= 1'b1;
                     pc_o <= vec_rdata_i;
                  end
                  5'd19: begin
                     state_reg <= ST_END;
                  end
                  default: begin
                  end
               endcase
            end
            ST_RET: begin
               cyc_reg <= cyc_reg + 5'd1;
               if (cyc_reg == 5'd0 || cyc_reg == 5'd2) begin
                  stack_re_o <= 1'b1;
                  stack_idx_o <= cyc_reg[2:1];
               end
               if (cyc_reg == 5'd1) begin
                  pop_hi_reg <= stack_rdata_i;
               end
               if (cyc_reg == 5'd3) begin
                  flg_we_o <= 1'b1;
                  flg_o <= pop_hi_reg[7:0];
                  ipl_we_o <= 1'b1;
                  ipl_o <= pop_hi_reg[10:8];
                  pc_we_o <= 1'b1;
                  pc_o <= {pop_hi_reg[15:12], stack_rdata_i};
                  state_reg <= ST_END;
               end
            end
            ST_END: begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // mia_core

// File: include/mia_consts.vh
`ifndef MIA_CONSTS_VH
`define MIA_CONSTS_VH
`define MIA_NSRC 32
`define MIA_ENTRY_CYCLES 20
`define MIA_IPL_SPECIAL 3'h7
`define MIA_INFO_ADDR 20'h00000
`define MIA_FLG_I 6
`define MIA_FLG_D 0
`define MIA_FLG_U 7
`define MIA_SW_U_LO 6'h20
`define MIA_SP_NONE 3'h0
`define MIA_SP_WDT 3'h1
`define MIA_SP_VMON 3'h2
`define MIA_SP_CMP 3'h3
`define MIA_SP_ABRK 3'h4
`define MIA_SP_AMATCH 3'h5
`define MIA_SP_STEP 3'h6
`define MIA_VEC_STEP 6'h04
`endif

// File: verilog/mia_arbiter.v
`timescale 1ns/1ns
`include "mia_consts.vh"
module mia_arbiter (
   input wire [`MIA_NSRC-1:0] pend_i,
   input wire [`MIA_NSRC*3-1:0] lvl_i,
   input wire [2:0] ipl_i,
   input wire i_flag_i,
   output reg hit_o,
   output reg [4:0] num_o,
   output reg [2:0] lvl_o
);
   integer k;
   reg [2:0] l;
   always @* begin
      hit_o = 1'b0;
      num_o = 5'h00;
      lvl_o = 3'h0;
      l = 3'h0;
      // Lower source number wins ties: the scan replaces only on a strictly higher level.
      for (k = 0; k < `MIA_NSRC; k = k + 1) begin
         l = lvl_i[k*3 +: 3];
         if (i_flag_i && pend_i[k] && (l > ipl_i) && (l != 3'h0) && (!hit_o || l > lvl_o)) begin
            hit_o = 1'b1;
            num_o = k[4:0];
            lvl_o = l;
         end
      end
   end
endmodule // mia_arbiter

// File: tb/mia_core_asserts.sv
`timescale 1ns/1ns
`include "mia_consts.vh"
module mia_core_asserts (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [`MIA_NSRC-1:0] src_req_i,
   input wire [`MIA_NSRC-1:0] pend_clr_i,
   input wire [2:0] special_i,
   input wire trap_i,
   input wire return_from_exception_instr_i,
   input wire [7:0] flg_i,
   input wire [2:0] ipl_i,
   input wire [`MIA_NSRC-1:0] pend_o,
   input wire busy_o,
   input wire info_rd_o,
   input wire [19:0] info_addr_o,
   input wire stack_we_o,
   input wire [1:0] stack_idx_o,
   input wire flg_we_o,
   input wire [7:0] flg_o,
   input wire pc_we_o,
   input wire done_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_save;
      (stack_we_o && stack_idx_o == 2'h0) ##2 (stack_we_o && stack_idx_o == 2'h1)
      ##2 (stack_we_o && stack_idx_o == 2'h2) ##2 (stack_we_o && stack_idx_o == 2'h3);
   endsequence
   a_info_addr_zero: assert property (info_rd_o |-> info_addr_o == 20'h00000)
      else $error("info read address wrong");
   a_entry_twenty: assert property (info_rd_o |-> ##18 pc_we_o ##2 done_o)
      else $error("entry length wrong");
   a_save_order: assert property (info_rd_o |-> ##4 s_save)
      else $error("stack save order wrong");
   a_flags_cleared: assert property (info_rd_o |-> ##2 (flg_we_o && !flg_o[6] && !flg_o[0]))
      else $error("entry flags not cleared");
   a_mask_blocks: assert property ((!busy_o && !trap_i && !return_from_exception_instr_i && special_i == 3'h0
      && (!flg_i[6] || ipl_i == 3'h7)) |=> !busy_o)
      else $error("masked request taken");
   a_trap_taken: assert property ((trap_i && !busy_o && !return_from_exception_instr_i) |=> busy_o)
      else $error("trap not taken");
   a_pend_set: assert property (|src_req_i |=> (pend_o & $past(src_req_i)) == $past(src_req_i))
      else $error("pending not set");
   a_pend_clear: assert property (|pend_clr_i |=>
      (pend_o & $past(pend_clr_i) & ~$past(src_req_i)) == '0)
      else $error("pending not cleared");
endmodule // mia_core_asserts

bind mia_core mia_core_asserts u_mia_core_asserts (.core_clk_i, .rst_n_i, .src_req_i, .pend_clr_i,
   .special_i, .trap_i, .return_from_exception_instr_i, .flg_i, .ipl_i, .pend_o, .busy_o, .info_rd_o, .info_addr_o,
   .stack_we_o, .stack_idx_o, .flg_we_o, .flg_o, .pc_we_o, .done_o);

// File: tb/mia_cpu_model.sv
`timescale 1ns/1ns
module mia_cpu_model (
   input wire clk_i,
   input wire swe_i,
   input wire sre_i,
   input wire [7:0] swd_i,
   input wire [1:0] sidx_i,
   input wire vrd_i,
   input wire [19:0] va_i,
   input wire fwe_i,
   input wire [7:0] fwd_i,
   input wire iwe_i,
   input wire [2:0] iwd_i,
   input wire pwe_i,
   input wire [19:0] pwd_i,
   output reg [7:0] flg_o,
   output reg [2:0] ipl_o,
   output reg [19:0] pc_o,
   output reg [19:0] vd_o,
   output reg [15:0] sd_o
);
   reg [7:0] mem [0:3];
   reg [1:0] hold;
   initial begin
      flg_o = 8'hc1;
      ipl_o = 3'h1;
      pc_o = 20'h5a3c7;
      vd_o = 20'h00000;
      sd_o = 16'h0000;
      hold = 2'h0;
   end
   // Strobes are taken at the falling edge, where the block's registered outputs are settled.
   always @(negedge clk_i) begin
      if (swe_i)
         mem[sidx_i] <= swd_i;
      if (fwe_i)
         flg_o <= fwd_i;
      if (iwe_i)
         ipl_o <= iwd_i;
      if (pwe_i)
         pc_o <= pwd_i;
      if (vrd_i)
         vd_o <= va_i ^ 20'h0a5a4;
      // A popped word is valid for two cycles, then scrambled so a late sample shows.
      if (sre_i) begin
         hold <= 2'h2;
         sd_o <= sidx_i[0] ? {mem[2], mem[3]} : {mem[0], mem[1]};
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
         if (hold == 2'h1)
            sd_o <= ~sd_o;
      end
   end
endmodule // mia_cpu_model

// File: tb/tb.sv
`timescale 1ns/1ns
`include "mia_consts.vh"
module tb;
   reg core_clk_i, rst_n_i, trap_i, instr_done_i, suspendable_i, return_from_exception_instr_i;
   reg [31:0] src_req_i, pend_clr_i, lvl_we_i;
   reg [95:0] lvl_wdata_i;
   reg [2:0] special_i;
   reg [5:0] special_vec_i, trap_num_i;
   reg [19:0] vector_table_base_i, vpc;
   wire [7:0] flg_i, flg_o, stack_wdata_o;
   wire [2:0] ipl_i, ipl_o;
   wire [19:0] pc_i, vec_rdata_i, vec_addr_o, pc_o;
   wire [15:0] stack_rdata_i;
   wire [31:0] pend_o;
   wire [95:0] lvl_o;
   wire [5:0] int_num_o;
   wire [1:0] stack_idx_o;
   wire busy_o, info_rd_o, stack_we_o, stack_re_o, vec_rd_o, flg_we_o, ipl_we_o, pc_we_o, done_o;
   wire suspend_o;
   wire [2:0] int_lvl_o;
   // The suspend strobe lasts one cycle, so it is caught here and judged after the sequence.
   reg susp_seen = 1'b0;
   integer err_total, total_checks;
   mia_core u_mia_core (.core_clk_i, .rst_n_i, .src_req_i, .pend_clr_i, .lvl_wdata_i, .lvl_we_i,
      .special_i, .special_vec_i, .trap_i, .trap_num_i, .instr_done_i, .suspendable_i, .return_from_exception_instr_i,
      .flg_i, .ipl_i, .pc_i, .vector_table_base_i, .vec_rdata_i, .stack_rdata_i, .pend_o, .lvl_o, .busy_o,
      .info_rd_o, .info_addr_o(), .int_num_o, .int_lvl_o, .stack_we_o, .stack_re_o,
      .stack_wdata_o, .stack_idx_o, .vec_rd_o, .vec_addr_o, .flg_we_o, .flg_o, .ipl_we_o, .ipl_o,
      .pc_we_o, .pc_o, .suspend_o, .done_o);
   always @(posedge core_clk_i) begin
      if (suspend_o === 1'b1)
         susp_seen <= 1'b1;
   end
   mia_cpu_model u_mia_cpu_model (.clk_i(core_clk_i), .swe_i(stack_we_o), .sre_i(stack_re_o),
      .swd_i(stack_wdata_o), .sidx_i(stack_idx_o), .vrd_i(vec_rd_o), .va_i(vec_addr_o),
      .fwe_i(flg_we_o), .fwd_i(flg_o), .iwe_i(ipl_we_o), .iwd_i(ipl_o), .pwe_i(pc_we_o),
      .pwd_i(pc_o), .flg_o(flg_i), .ipl_o(ipl_i), .pc_o(pc_i), .vd_o(vec_rdata_i),
      .sd_o(stack_rdata_i));
   task chk(input [31:0] got, input [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cpu(input [7:0] f, input [2:0] l);
      @(negedge core_clk_i);
      u_mia_cpu_model.flg_o = f;
      u_mia_cpu_model.ipl_o = l;
   endtask
   task run(input [3:0] sel, input wt);
      integer n;
      @(negedge core_clk_i);
      {return_from_exception_instr_i, trap_i, suspendable_i, instr_done_i} = sel;
      @(negedge core_clk_i);
      {return_from_exception_instr_i, trap_i, suspendable_i, instr_done_i} = 4'h0;
      for (n = 0; wt && n < 40 && done_o !== 1'b1; n++)
         @(negedge core_clk_i);
      if (wt)
         chk(done_o, 1'b1);
   endtask
   task t_tie;
      lvl_wdata_i[9+:3] = 3'h3;
      lvl_wdata_i[15+:3] = 3'h3;
      lvl_we_i = 32'h28;
      src_req_i = 32'h28;
      @(negedge core_clk_i);
      lvl_we_i = 32'h0;
      src_req_i = 32'h0;
      run(4'h1, 1'b1);
      chk({int_num_o, pend_o[5:3]}, {6'd3, 3'h4});
      chk({int_lvl_o, susp_seen}, {3'h3, 1'b0});
      chk({flg_i, ipl_i, pc_i}, {8'h00, 3'h3, vpc});
      chk({u_mia_cpu_model.mem[0], u_mia_cpu_model.mem[1]}, 16'h51c1);
      chk({u_mia_cpu_model.mem[2], u_mia_cpu_model.mem[3]}, 16'ha3c7);
   endtask
   task t_block;
      cpu(8'h40, 3'h3);
      run(4'h1, 1'b0);
      chk(busy_o, 1'b0);
      pend_clr_i = 32'h20;
      lvl_wdata_i[15+:3] = 3'h5;
      lvl_we_i = 32'h20;
      @(negedge core_clk_i);
      pend_clr_i = 32'h0;
      lvl_we_i = 32'h0;
      @(negedge core_clk_i);
      chk({pend_o[5], lvl_o[9+:3], lvl_o[15+:3]}, 7'h1d);
   endtask
   task t_suspend_return;
      src_req_i = 32'h20;
      @(negedge core_clk_i);
      src_req_i = 32'h0;
      run(4'h2, 1'b1);
      chk({int_num_o, ipl_i}, {6'd5, 3'h5});
      chk({int_lvl_o, susp_seen}, {3'h5, 1'b1});
      run(4'h8, 1'b1);
      chk({flg_i, ipl_i, pc_i}, {8'h40, 3'h3, vpc});
   endtask
   task t_special_trap;
      cpu(8'h80, 3'h2);
      special_i = `MIA_SP_WDT;
      run(4'h1, 1'b1);
      special_i = 3'h0;
      chk({flg_i, ipl_i}, {8'h00, 3'h7});
      cpu(8'h81, 3'h2);
      run(4'h4, 1'b1);
      chk({flg_i, ipl_i, pc_i}, {8'h80, 3'h2, (vector_table_base_i + 20'h00084) ^ 20'h0a5a4});
   endtask
   task end_sim;
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // The full run needs about 110 cycles; the limit leaves a wide margin.
   initial begin
      #100000;
      err_total++;
      end_sim;
   end
   initial begin
      {rst_n_i, trap_i, instr_done_i, suspendable_i, return_from_exception_instr_i} = 5'h0;
      {src_req_i, pend_clr_i, lvl_we_i, lvl_wdata_i} = 192'h0;
      {special_i, special_vec_i} = 9'h00a;
      trap_num_i = 6'h21;
      vector_table_base_i = 20'h1c400;
      vpc = (20'h1c400 + 20'h0000c) ^ 20'h0a5a4;
      err_total = 0;
      total_checks = 0;
      repeat (3) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      t_tie;
      t_block;
      t_suspend_return;
      t_special_trap;
      end_sim;
   end
endmodule // tb
